// [verilog/ddcns_top.sv]
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "ddcns_map.svh"
// Operation
// - integer mode: step equals frequency word
// - four accumulators per channel, always running
// - select from pins or register field
// - frequency rewrite makes phase unknown until sync
// - rational mode lands exactly on step multiples
// - offset word shifted up, added to phase
// - sync at link init or sysref
// - link init sync needs enable and link
// - armed: next sysref edge resets all phases
// - decimate 2 real, 4/8/16 complex, 15 bits
// - stage chain chosen by decimation factor
// - symmetric taps folded about center tap
////////////////////////////////////////////////////////////////////////////
module ddcns_top (
  // clock and reset
  input logic clk_sys,
  input logic resetn,
  // wishbone slave
  input ddcns_pkg::ddcns_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // converter samples
  input logic signed [11:0] chan_a_sample,
  input logic signed [11:0] chan_b_sample,
  // asynchronous pins
  input logic [1:0] chan_a_osc_select_pins,
  input logic [1:0] chan_b_osc_select_pins,
  input logic sysref_pin,
  input logic link_sync_n,
  // decimated streams
  output ddcns_pkg::ddcns_out_t chan_a_out,
  output ddcns_pkg::ddcns_out_t chan_b_out
);
  localparam int NCO_TOT = 2 * `DDCNS_NCO_CNT;
  localparam logic [15:0] SIN_TAB [16] = '{
    16'h0648, 16'h12c8, 16'h1f1a, 16'h2b1f, 16'h36ba, 16'h41ce,
    16'h4c3f, 16'h55f5, 16'h5ed7, 16'h66cf, 16'h6dc9, 16'h73b5,
    16'h7884, 16'h7c29, 16'h7e9c, 16'h7fd8};

  logic [`DDCNS_CTRL_W-1:0] ctrl_reg;
  logic [15:0] rdiv_reg;
  logic [31:0] freq_reg [NCO_TOT];
  logic [15:0] phase_reg [NCO_TOT];
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic armed_reg;
  logic unknown_reg;
  logic [5:0] meta_reg;
  logic [5:0] pin_reg;
  logic [1:0] prev_reg;
  logic [31:0] acc_reg [NCO_TOT];
  logic signed [17:0] err_reg [NCO_TOT];
  ddcns_pkg::ddcns_nco_t nco_nx [NCO_TOT];
  logic [1:0] sel_reg [2];
  logic [31:0] ph_reg [2];
  logic signed [11:0] samp1_reg [2];
  logic signed [11:0] samp2_reg [2];
  logic signed [15:0] cos_reg [2];
  logic signed [15:0] sin_reg [2];
  ddcns_pkg::ddcns_iq_t mix_reg [2];
  ddcns_pkg::ddcns_iq_t fin_s [2];
  ddcns_pkg::ddcns_out_t out_reg [2];
  logic [31:0] rd_val;
  logic req;
  logic wr_take;
  logic sysref_rise;
  logic sync_rise;
  logic phase_reset;
  logic is_freq;
  ddcns_pkg::ddcns_dec_t dec;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_win(logic [7:0] adr, logic [7:0] base);
    return (adr & `DDCNS_WIN_MASK) == base;
  endfunction

  function automatic logic signed [15:0] wave(logic [31:0] ph);
    logic [3:0] k;
    logic signed [15:0] mag;
    k = ph[30] ? ~ph[29:26] : ph[29:26];
    mag = signed'(SIN_TAB[k]);
    return ph[31] ? -mag : mag;
  endfunction

  function automatic ddcns_pkg::ddcns_nco_t nco_next(logic [31:0] acc,
    logic signed [17:0] err, logic [31:0] fw, logic [15:0] rd);
    logic [47:0] prod;
    logic [21:0] n;
    logic signed [17:0] e;
    logic signed [17:0] rds;
    ddcns_pkg::ddcns_nco_t r;
    prod = fw * rd;
    n = prod[47:26] + 22'(prod[25]);
    rds = signed'({2'b00, rd});
    e = err + signed'(18'({n, 26'h0} - prod));
    r.acc = acc + fw;
    r.err = 18'sh00000;
    if (rd != 16'h0000) begin
      // residue of the rounded word carried until it makes one lsb
      r.err = e;
      if (e >= rds) begin
        r.acc = acc + fw + 32'h1;
        r.err = e - rds;
      end else if (e <= -rds) begin
        r.acc = acc + fw - 32'h1;
        r.err = e + rds;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state
  assign req = wb_req.cyc && wb_req.stb;
  assign wr_take = req && wb_req.we && ack_reg;
  assign is_freq = in_win(wb_req.adr, `DDCNS_FREQ_BASE);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wb_req.adr == `DDCNS_CTRL_OFS) begin
      rd_val = {21'h0, ctrl_reg};
    end else if (wb_req.adr == `DDCNS_RDIV_OFS) begin
      rd_val = {16'h0, rdiv_reg};
    end else if (wb_req.adr == `DDCNS_STAT_OFS) begin
      rd_val = {26'h0, sel_reg[1], sel_reg[0], unknown_reg, armed_reg};
    end else if (is_freq) begin
      rd_val = freq_reg[wb_req.adr[4:2]];
    end else if (in_win(wb_req.adr, `DDCNS_PHASE_BASE)) begin
      rd_val = {16'h0, phase_reg[wb_req.adr[4:2]]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) begin
        rdat_reg <= rd_val;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= `DDCNS_CTRL_RESET;
      rdiv_reg <= `DDCNS_RDIV_RESET;
      for (int k = 0; k < NCO_TOT; k++) begin
        freq_reg[k] <= `DDCNS_FREQ_RESET;
        phase_reg[k] <= `DDCNS_PHASE_RESET;
      end
    end else if (wr_take) begin
      if (wb_req.adr == `DDCNS_CTRL_OFS) begin
        ctrl_reg <= `DDCNS_CTRL_W'(merge({21'h0, ctrl_reg}, wb_req.dat,
                                         wb_req.sel));
      end
      if (wb_req.adr == `DDCNS_RDIV_OFS) begin
        rdiv_reg <= 16'(merge({16'h0, rdiv_reg}, wb_req.dat, wb_req.sel));
      end
      if (is_freq) begin
        freq_reg[wb_req.adr[4:2]] <= merge(freq_reg[wb_req.adr[4:2]],
                                           wb_req.dat, wb_req.sel);
      end
      if (in_win(wb_req.adr, `DDCNS_PHASE_BASE)) begin
        phase_reg[wb_req.adr[4:2]] <= 16'(merge(
          {16'h0, phase_reg[wb_req.adr[4:2]]}, wb_req.dat, wb_req.sel));
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, edges taken from the second stage only
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // sync idles high: reset to its idle level, no false edge after reset
      meta_reg <= 6'h20;
      pin_reg <= 6'h20;
      prev_reg <= 2'h2;
    end else begin
      meta_reg <= {link_sync_n, sysref_pin, chan_b_osc_select_pins,
                   chan_a_osc_select_pins};
      pin_reg <= meta_reg;
      prev_reg <= pin_reg[5:4];
    end
  end

  assign sysref_rise = pin_reg[4] && !prev_reg[0];
  assign sync_rise = pin_reg[5] && !prev_reg[1];
  assign phase_reset = (ctrl_reg[`DDCNS_ILA_BIT] &&
                        ctrl_reg[`DDCNS_LINK_EN_BIT] && sync_rise) ||
                       (armed_reg && sysref_rise);

  // arming needs a 0 to 1 write; a new arm beats a same-cycle edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (wr_take && wb_req.adr == `DDCNS_CTRL_OFS &&
                 wb_req.sel[0] && wb_req.dat[`DDCNS_ARM_BIT] &&
                 !ctrl_reg[`DDCNS_ARM_BIT]) begin
      armed_reg <= 1'b1;
    end else if (sysref_rise) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      unknown_reg <= 1'b0;
    end else if (wr_take && is_freq) begin
      unknown_reg <= 1'b1;
    end else if (phase_reset) begin
      unknown_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator bank, unselected accumulators keep running
  always_comb begin
    for (int k = 0; k < NCO_TOT; k++) begin
      nco_nx[k] = nco_next(acc_reg[k], err_reg[k], freq_reg[k], rdiv_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < NCO_TOT; k++) begin
      if (!resetn || phase_reset) begin
        acc_reg[k] <= 32'h0000_0000;
        err_reg[k] <= 18'sh00000;
      end else begin
        acc_reg[k] <= nco_nx[k].acc;
        err_reg[k] <= nco_nx[k].err;
      end
    end
  end

  // select, phase, wave, mix: four stages per channel
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (!resetn) begin
        sel_reg[c] <= 2'h0;
        ph_reg[c] <= 32'h0000_0000;
        samp1_reg[c] <= 12'sh000;
        samp2_reg[c] <= 12'sh000;
        cos_reg[c] <= 16'sh0000;
        sin_reg[c] <= 16'sh0000;
        mix_reg[c] <= '0;
      end else begin
        sel_reg[c] <= ctrl_reg[`DDCNS_SRC_BIT] ? pin_reg[2*c +: 2] :
                      ctrl_reg[`DDCNS_SEL_A_LSB + 2*c +: 2];
        ph_reg[c] <= acc_reg[4*c + int'(sel_reg[c])] +
                     {phase_reg[4*c + int'(sel_reg[c])], 16'h0};
        samp1_reg[c] <= (c == 0) ? chan_a_sample : chan_b_sample;
        samp2_reg[c] <= samp1_reg[c];
        cos_reg[c] <= wave(ph_reg[c] + `DDCNS_QUARTER_TURN);
        sin_reg[c] <= wave(ph_reg[c]);
        mix_reg[c].valid <= 1'b1;
        mix_reg[c].i <= 16'((28'(samp2_reg[c] * cos_reg[c])) >>> 11);
        mix_reg[c].q <= 16'((28'(samp2_reg[c] * sin_reg[c])) >>> 11);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decimation chains
  assign dec = ddcns_pkg::ddcns_dec_t'(ctrl_reg[`DDCNS_DEC_LSB +: 2]);

  for (genvar c = 0; c < 2; c++) begin : g_chan
    ddcns_pkg::ddcns_iq_t s10, s20, s40, s45, s80, s87;
    ddcns_pkg::ddcns_iq_t in20, in80, real_s;
    // real path skips the mixer
    assign real_s = '{valid: 1'b1, i: {samp2_reg[c], 4'h0}, q: 16'sh0000};
    assign in20 = (dec == ddcns_pkg::DEC_16) ? s10 : mix_reg[c];
    assign in80 = (dec == ddcns_pkg::DEC_2) ? real_s :
                  (dec == ddcns_pkg::DEC_4) ? s45 : s40;
    assign fin_s[c] = (dec == ddcns_pkg::DEC_4 &&
                       ctrl_reg[`DDCNS_WIDE_BIT]) ? s87 : s80;
    ddcns_hb_stage u_stage_10 (.clk_sys(clk_sys), .resetn(resetn),
                               .in_s(mix_reg[c]), .out_s(s10));
    ddcns_hb_stage u_stage_20 (.clk_sys(clk_sys), .resetn(resetn),
                               .in_s(in20), .out_s(s20));
    ddcns_hb_stage u_stage_40 (.clk_sys(clk_sys), .resetn(resetn),
                               .in_s(s20), .out_s(s40));
    ddcns_hb_stage u_stage_45 (.clk_sys(clk_sys), .resetn(resetn),
                               .in_s(mix_reg[c]), .out_s(s45));
    ddcns_hb_stage u_stage_80 (.clk_sys(clk_sys), .resetn(resetn),
                               .in_s(in80), .out_s(s80));
    ddcns_hb_stage #(.TAP_A(16'shf800), .TAP_B(16'sh2800))
      u_stage_87 (.clk_sys(clk_sys), .resetn(resetn),
                  .in_s(s45), .out_s(s87));
  end

  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (!resetn) begin
        out_reg[c] <= '0;
      end else begin
        out_reg[c].valid <= fin_s[c].valid;
        out_reg[c].i <= fin_s[c].i[15:1];
        out_reg[c].q <= fin_s[c].q[15:1];
      end
    end
  end

  assign chan_a_out = out_reg[0];
  assign chan_b_out = out_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_armed_edge;
    armed_reg && sysref_rise;
  endsequence

  sequence s_ila_edge;
    ctrl_reg[`DDCNS_ILA_BIT] && ctrl_reg[`DDCNS_LINK_EN_BIT] && sync_rise;
  endsequence

  chk_sysref_phase_zero: assert property (
    s_armed_edge |=> acc_reg[0] == 32'h0 && acc_reg[7] == 32'h0)
    else $error("armed sysref edge did not clear phases");
  chk_ila_phase_zero: assert property (
    s_ila_edge |=> acc_reg[4] == 32'h0 &&
      (!unknown_reg || $past(wr_take && is_freq)))
    else $error("link init sync did not clear phases");
  chk_acc_keeps_running: assert property (
    (rdiv_reg == 16'h0 && !phase_reset) |=>
      acc_reg[1] == $past(acc_reg[1]) + $past(freq_reg[1]))
    else $error("idle accumulator did not advance by its word");
  chk_freq_write_unknown: assert property (
    (wr_take && is_freq && !phase_reset) |=> unknown_reg [*1] ##1 1'b1)
    else $error("frequency write did not flag unknown phase");
  chk_sel_source: assert property (
    ##1 sel_reg[1] == ($past(ctrl_reg[`DDCNS_SRC_BIT]) ?
      $past(pin_reg[3:2]) : $past(ctrl_reg[`DDCNS_SEL_B_LSB +: 2])))
    else $error("wrong oscillator selection source");
  chk_offset_added: assert property (
    ##1 ph_reg[0] == $past(acc_reg[sel_reg[0]]) +
      {$past(phase_reg[sel_reg[0]]), 16'h0})
    else $error("phase offset not added to accumulator");
  chk_dec2_spacing: assert property (
    (dec == ddcns_pkg::DEC_2 && $stable(dec) && chan_a_out.valid) |=>
      !chan_a_out.valid)
    else $error("decimate by 2 output came on back to back clocks");
  chk_mixer_zero_in: assert property (
    (samp2_reg[0] == 12'sh000) |=> mix_reg[0].i == 16'sh0000 &&
      mix_reg[0].q == 16'sh0000)
    else $error("zero sample did not mix to zero");

endmodule // ddcns_top

// [verilog/ddcns_map.svh]
`ifndef DDCNS_MAP_SVH
`define DDCNS_MAP_SVH

// register byte offsets
`define DDCNS_CTRL_OFS 8'h00
`define DDCNS_RDIV_OFS 8'h04
`define DDCNS_STAT_OFS 8'h08
`define DDCNS_FREQ_BASE 8'h20
`define DDCNS_PHASE_BASE 8'h40
`define DDCNS_WIN_MASK 8'he0

// control field positions
`define DDCNS_CTRL_W 11
`define DDCNS_LINK_EN_BIT 0
`define DDCNS_ILA_BIT 1
`define DDCNS_ARM_BIT 2
`define DDCNS_WIDE_BIT 3
`define DDCNS_SRC_BIT 4
`define DDCNS_SEL_A_LSB 5
`define DDCNS_SEL_B_LSB 7
`define DDCNS_DEC_LSB 9

// reset values
`define DDCNS_CTRL_RESET 11'h000
`define DDCNS_RDIV_RESET 16'h0000
`define DDCNS_FREQ_RESET 32'h0000_0000
`define DDCNS_PHASE_RESET 16'h0000

// oscillator arithmetic
`define DDCNS_NCO_CNT 4
`define DDCNS_RATIONAL_SHIFT 26
`define DDCNS_QUARTER_TURN 32'h4000_0000

`endif

// [verilog/ddcns_pkg.sv]
package ddcns_pkg;

  typedef enum logic [1:0] {DEC_2, DEC_4, DEC_8, DEC_16} ddcns_dec_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ddcns_wb_req_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] i;
    logic signed [15:0] q;
  } ddcns_iq_t;

  typedef struct packed {
    logic valid;
    logic signed [14:0] i;
    logic signed [14:0] q;
  } ddcns_out_t;

  typedef struct packed {
    logic [31:0] acc;
    logic signed [17:0] err;
  } ddcns_nco_t;

endpackage

// [verilog/ddcns_hb_stage.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module ddcns_hb_stage #(
  parameter logic signed [15:0] TAP_A = 16'shf99a,
  parameter logic signed [15:0] TAP_B = 16'sh2666,
  parameter logic signed [15:0] TAP_C = 16'sh4000
) (
  // clock and reset
  input logic clk_sys,
  input logic resetn,
  // stream
  input ddcns_pkg::ddcns_iq_t in_s,
  output ddcns_pkg::ddcns_iq_t out_s
);
  logic signed [15:0] di [7];
  logic signed [15:0] dq [7];
  logic keep_reg;

  // folded 7-tap half band, outer pair, inner pair, center
  function automatic logic signed [15:0] fold(
    logic signed [15:0] x0, logic signed [15:0] x2,
    logic signed [15:0] x3, logic signed [15:0] x4,
    logic signed [15:0] x6);
    logic signed [34:0] acc;
    acc = 35'(TAP_A * 17'(x0 + x6)) + 35'(TAP_B * 17'(x2 + x4)) +
          35'(TAP_C * x3);
    // no saturation: taps sum to unity gain
    return 16'(acc >>> 15);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int k = 0; k < 7; k++) begin
        di[k] <= 16'sh0000;
        dq[k] <= 16'sh0000;
      end
      keep_reg <= 1'b0;
    end else if (in_s.valid) begin
      di[0] <= in_s.i;
      dq[0] <= in_s.q;
      for (int k = 1; k < 7; k++) begin
        di[k] <= di[k-1];
        dq[k] <= dq[k-1];
      end
      keep_reg <= !keep_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_s <= '0;
    end else begin
      out_s.valid <= in_s.valid && keep_reg;
      if (in_s.valid && keep_reg) begin
        out_s.i <= fold(di[0], di[2], di[3], di[4], di[6]);
        out_s.q <= fold(dq[0], dq[2], dq[3], dq[4], dq[6]);
      end
    end
  end

endmodule // ddcns_hb_stage

// [verif/ddcns_rx_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module ddcns_rx_model (
  // clock
  input wire logic clk_sys,
  // pins toward the converter
  output logic sysref_pin,
  output logic link_sync_n
);
  // sysref held low between pulses, sync released while link is down
  initial begin
    sysref_pin = 1'b0;
    link_sync_n = 1'b1;
  end

  // lone trigger pulse, launched on the same edge grid as alignment
  task automatic sysref_pulse(input int hi);
    @(posedge clk_sys);
    sysref_pin <= 1'b1;
    repeat (hi) @(posedge clk_sys);
    sysref_pin <= 1'b0;
  endtask

  // request code groups, then release to every converter at once
  task automatic cgs_cycle(input int lo);
    @(posedge clk_sys);
    link_sync_n <= 1'b0;
    repeat (lo) @(posedge clk_sys);
    link_sync_n <= 1'b1;
  endtask
endmodule // ddcns_rx_model

// [verif/ddcns_top_tb_top.sv]
`timescale 1ns/1ps
`include "ddcns_map.svh"
module ddcns_top_tb_top;
  typedef struct {
    string name;
    logic [31:0] exp;
    logic [31:0] mask;
  } ddcns_note_t;
  logic clk_sys;
  logic resetn;
  ddcns_pkg::ddcns_wb_req_t wb_req;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic signed [11:0] chan_a_sample;
  logic signed [11:0] chan_b_sample;
  logic [1:0] sel_pins_a;
  logic [1:0] sel_pins_b;
  logic sysref_pin;
  logic link_sync_n;
  ddcns_pkg::ddcns_out_t chan_a_out;
  ddcns_pkg::ddcns_out_t chan_b_out;
  ddcns_note_t notes[$];
  ddcns_note_t cur;
  int errors = 0;
  int checks_done = 0;
  logic rand_on = 1'b1;
  logic [31:0] v;
  int dec_tab[5] = '{0, 1, 1, 2, 3};
  int wide_tab[5] = '{0, 0, 1, 0, 0};

  ddcns_top DUT (
    .clk_sys(clk_sys), .resetn(resetn), .wb_req(wb_req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
    .chan_a_osc_select_pins(sel_pins_a),
    .chan_b_osc_select_pins(sel_pins_b),
    .sysref_pin(sysref_pin), .link_sync_n(link_sync_n),
    .chan_a_out(chan_a_out), .chan_b_out(chan_b_out)
  );
  ddcns_rx_model rx (
    .clk_sys(clk_sys), .sysref_pin(sysref_pin), .link_sync_n(link_sync_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus master: caller stands just after a rising edge
  task automatic wb_cyc(input logic we, input logic [7:0] a,
                        input logic [31:0] d, input logic [31:0] m,
                        input string nm);
    int t;
    notes.push_back('{nm, d, m});
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) check("wb ack", 32'h1, 32'(wb_ack_o));
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    wb_req.we <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cyc(1'b1, a, d, 32'h0, "write");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string nm);
    wb_cyc(1'b0, a, e, m, nm);
  endtask

  // read data is taken at the edge that samples ack high
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.mask != 32'h0) check(cur.name, cur.exp & cur.mask,
                                   wb_dat_o & cur.mask);
    end
  end

  always @(posedge clk_sys) begin
    if (rand_on) begin
      chan_a_sample <= 12'($urandom);
      chan_b_sample <= 12'($urandom);
    end
  end

  task automatic gap(input int e, input logic real_out);
    int n;
    int w;
    w = 0;
    do begin
      @(negedge clk_sys);
      w++;
    end while (chan_a_out.valid !== 1'b1 && w < 100);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (chan_a_out.valid !== 1'b1 && n < 100);
    check("output spacing", 32'(e), 32'(n));
    check("chan b in step", 32'h1, 32'(chan_b_out.valid));
    if (real_out) check("real q", 32'h0, 32'(chan_a_out.q));
    if (real_out) check("real q b", 32'h0, 32'(chan_b_out.q));
    @(posedge clk_sys);
  endtask

  task automatic dominance(input logic q_big);
    int i;
    int q;
    repeat (300) @(posedge clk_sys);
    @(negedge clk_sys);
    while (chan_a_out.valid !== 1'b1) @(negedge clk_sys);
    i = chan_a_out.i < 0 ? -chan_a_out.i : chan_a_out.i;
    q = chan_a_out.q < 0 ? -chan_a_out.q : chan_a_out.q;
    check("quadrant", 32'h1, 32'(q_big ? q > 4 * i : i > 4 * q));
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    wb_req = '0;
    resetn = 1'b0;
    chan_a_sample = 12'h000;
    chan_b_sample = 12'h000;
    sel_pins_a = 2'h0;
    sel_pins_b = 2'h0;
    void'($urandom(6));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(`DDCNS_CTRL_OFS, 32'h0, 32'hffffffff, "ctrl reset");
    rd(`DDCNS_RDIV_OFS, 32'h0, 32'hffffffff, "rdiv reset");
    rd(`DDCNS_FREQ_BASE, 32'h0, 32'hffffffff, "freq reset");
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0, 32'hffffffff, "unmapped");
    $display("test registers done");
    v = $urandom;
    wr(`DDCNS_FREQ_BASE + 8'h04, v);
    rd(`DDCNS_FREQ_BASE + 8'h04, v, 32'hffffffff, "freq word");
    rd(`DDCNS_STAT_OFS, 32'h2, 32'h3, "unknown set");
    rx.sysref_pulse(2);
    repeat (8) @(posedge clk_sys);
    rd(`DDCNS_STAT_OFS, 32'h2, 32'h3, "unarmed edge");
    wr(`DDCNS_CTRL_OFS, 32'h1);
    wr(`DDCNS_CTRL_OFS, 32'h5);
    rd(`DDCNS_STAT_OFS, 32'h3, 32'h3, "armed");
    rx.sysref_pulse(2);
    repeat (8) @(posedge clk_sys);
    rd(`DDCNS_STAT_OFS, 32'h0, 32'h3, "sysref sync");
    $display("test sysref done");
    wr(`DDCNS_CTRL_OFS, 32'h2);
    wr(`DDCNS_FREQ_BASE + 8'h04, v);
    rx.cgs_cycle(4);
    repeat (8) @(posedge clk_sys);
    rd(`DDCNS_STAT_OFS, 32'h2, 32'h2, "link off edge");
    wr(`DDCNS_CTRL_OFS, 32'h3);
    rx.cgs_cycle(4);
    repeat (8) @(posedge clk_sys);
    rd(`DDCNS_STAT_OFS, 32'h0, 32'h2, "link sync");
    $display("test link sync done");
    sel_pins_a <= 2'h3;
    sel_pins_b <= 2'h1;
    wr(`DDCNS_CTRL_OFS, 32'h2 << `DDCNS_SEL_A_LSB);
    rd(`DDCNS_STAT_OFS, 32'h08, 32'h3c, "field select");
    wr(`DDCNS_CTRL_OFS, 32'h1 << `DDCNS_SRC_BIT);
    repeat (5) @(posedge clk_sys);
    rd(`DDCNS_STAT_OFS, 32'h1c, 32'h3c, "pin select");
    $display("test selection done");
    for (int k = 0; k < 5; k++) begin
      wr(`DDCNS_CTRL_OFS, (32'(dec_tab[k]) << `DDCNS_DEC_LSB) |
                          (32'(wide_tab[k]) << `DDCNS_WIDE_BIT));
      repeat (60) @(posedge clk_sys);
      gap(2 << dec_tab[k], dec_tab[k] == 0);
    end
    $display("test decimation done");
    rand_on <= 1'b0;
    @(posedge clk_sys);
    chan_a_sample <= 12'h000;
    repeat (4) @(posedge clk_sys);
    chan_a_sample <= 12'(256 + ($urandom % 512));
    wr(`DDCNS_CTRL_OFS, 32'h1 << `DDCNS_DEC_LSB);
    dominance(1'b0);
    wr(`DDCNS_PHASE_BASE, 32'h4000);
    dominance(1'b1);
    $display("test phase offset done");
    wr(`DDCNS_RDIV_OFS, 32'h0000_0780);
    rd(`DDCNS_RDIV_OFS, 32'h780, 32'hffff, "divider");
    // word for 502 steps of 10 kHz, rounded, on an unselected oscillator
    wr(`DDCNS_FREQ_BASE + 8'h08, 32'h010b_bbbc);
    repeat (4) @(posedge clk_sys);
    v = DUT.acc_reg[2];
    repeat (1920) @(posedge clk_sys);
    // one divider period must advance by exactly 502 * 2^26 mod 2^32
    check("exact step", 32'hd800_0000, DUT.acc_reg[2] - v);
    $display("test rational done");
    report_and_stop();
  end
endmodule // ddcns_top_tb_top
